// ---- hdl/bwst_pkg.sv ----
// Package for the basic watchdog and stabilization timer.
// Assumes one 100 MHz clock and the CPU register port of the device.
package bwst_pkg;
   // Register addresses on the CPU register port
   localparam logic [7:0] BWST_ADDR_CONTROL = 8'hd3;
   localparam logic [7:0] BWST_ADDR_COUNT = 8'hfd;
   // Control register reset value and field layout
   localparam logic [7:0] BWST_CONTROL_RESET = 8'h00;
   localparam int BWST_SIG_HI = 7;
   localparam int BWST_SIG_LO = 4;
   localparam int BWST_SEL_HI = 3;
   localparam int BWST_SEL_LO = 2;
   localparam int BWST_CNT_CLR_BIT = 1;
   localparam int BWST_DIV_CLR_BIT = 0;
   // Signature that turns the watchdog off
   localparam logic [3:0] BWST_WDT_OFF_SIG = 4'ha;
   // Divider selections
   localparam logic [1:0] BWST_SEL_DIV4096 = 2'h0;
   localparam logic [1:0] BWST_SEL_DIV1024 = 2'h1;
   localparam logic [1:0] BWST_SEL_DIV128 = 2'h2;
   localparam logic [1:0] BWST_SEL_DIV16 = 2'h3;
   // Divider ratios
   localparam int BWST_DIV_MAX = 4096;
   localparam int BWST_DIV_B = 1024;
   localparam int BWST_DIV_C = 128;
   localparam int BWST_DIV_D = 16;
   // Counter bit whose carry ends the stabilization interval
   localparam int BWST_STAB_BIT = 4;
   // Timer states
   typedef enum logic [1:0] {
      BWST_RUN = 2'b00,
      BWST_STOPPED = 2'b01,
      BWST_STAB = 2'b11
   } bwst_state_type;
endpackage

// ---- hdl/bwst_prescaler.sv ----
// Prescaler for the basic timer: free-running divider with tick selection.
// Assumes a single clock; clear and selection come from the same domain.
`timescale 1ns/1ps
`default_nettype none
module bwst_prescaler #(
   parameter int DIV_WIDTH = 12
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic [1:0] select,
   output logic tick
);
   // Divider counter
   logic [DIV_WIDTH-1:0] div_r;
   logic [DIV_WIDTH-1:0] div_nxt;
   // Terminal-count flags for each ratio
   wire logic end_a;
   wire logic end_b;
   wire logic end_c;
   wire logic end_d;
   // Low divider widths for the shorter ratios
   localparam int B_W = $clog2(bwst_pkg::BWST_DIV_B);
   localparam int C_W = $clog2(bwst_pkg::BWST_DIV_C);
   localparam int D_W = $clog2(bwst_pkg::BWST_DIV_D);

   // Refuse a divider that cannot serve the longest ratio
   if ((1 << DIV_WIDTH) != bwst_pkg::BWST_DIV_MAX) begin : g_bad_width
      $error("bwst_prescaler: DIV_WIDTH must match largest ratio");
   end

   assign div_nxt = clear ? '0 : div_r + 1'b1;
   assign end_a = (div_r == DIV_WIDTH'(bwst_pkg::BWST_DIV_MAX - 1));
   assign end_b = (div_r[B_W-1:0] == B_W'(bwst_pkg::BWST_DIV_B - 1));
   assign end_c = (div_r[C_W-1:0] == C_W'(bwst_pkg::BWST_DIV_C - 1));
   assign end_d = (div_r[D_W-1:0] == D_W'(bwst_pkg::BWST_DIV_D - 1));

   // Tick mux, one pulse per selected period
   always_comb begin
      unique case (select)
         bwst_pkg::BWST_SEL_DIV4096: tick = end_a & ~clear;
         bwst_pkg::BWST_SEL_DIV1024: tick = end_b & ~clear;
         bwst_pkg::BWST_SEL_DIV128: tick = end_c & ~clear;
         bwst_pkg::BWST_SEL_DIV16: tick = end_d & ~clear;
      endcase
   end

   // Divider register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end
endmodule // bwst_prescaler
`default_nettype wire

// ---- hdl/bwst_timer.sv ----
// Basic watchdog and oscillation stabilization timer.
// Assumes a CPU register port (addr, write strobe, data) on the same clock,
// and stop, interrupt wake and reset-wake flags coming from pins.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Prescaled count clock: divide 4096/1024/128/16.
// - Eight-bit up-counter, readable, not writable.
// - Reset clears control: watchdog on, 4096.
// - Signature 1010 in upper bits disables watchdog.
// - Writing one to bit 1 clears counter.
// - Writing one to bit 0 clears prescaler.
// - Counter bit 7 overflow resets chip.
// - Stop-mode wake starts stabilization count.
// - Reset wake uses 4096; interrupt keeps selection.
// - Bit 4 overflow ends stabilization, resumes CPU.
// - Interrupt wake leaves clock selection unchanged.
module bwst_timer (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic stop_request,
   input wire logic wake_interrupt,
   input wire logic wake_after_reset,
   output logic cpu_clock_enable,
   output logic stabilization_done,
   output logic watchdog_reset
);
   // Synchronisers for the two wake pin inputs; stop_request is used unsynchronised
   logic [1:0] wake_int_sync_r;
   logic [1:0] wake_rst_sync_r;
   // Control register and counter
   logic [7:0] control_r;
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   // Timer state
   bwst_pkg::bwst_state_type state_r;
   bwst_pkg::bwst_state_type state_nxt;
   // Forced 4096 rate while stabilizing after reset
   logic force_slow_r;
   // Registered outputs
   logic [7:0] rdata_r;
   logic cpu_en_r;
   logic done_r;
   logic wdt_rst_r;

   // Decode wires
   wire logic wr_control;
   wire logic clr_count;
   wire logic clr_div;
   wire logic wdt_enabled;
   wire logic [1:0] sel_eff;
   wire logic tick;
   wire logic wake_int;
   wire logic wake_rst;
   wire logic [8:0] count_inc;
   wire logic stab_carry;
   wire logic counting;
   wire logic [7:0] rdata_sel; // Read data before the output register
   wire logic stab_end; // Last tick of the stabilization interval
   wire logic wdt_fire; // Overflow out of bit 7 while the watchdog may act

   assign wake_int = wake_int_sync_r[1];
   assign wake_rst = wake_rst_sync_r[1];
   assign wr_control = reg_write & (reg_addr == bwst_pkg::BWST_ADDR_CONTROL);
   assign clr_count = wr_control & reg_wdata[bwst_pkg::BWST_CNT_CLR_BIT];
   assign clr_div = wr_control & reg_wdata[bwst_pkg::BWST_DIV_CLR_BIT];
   assign wdt_enabled =
      (control_r[bwst_pkg::BWST_SIG_HI:bwst_pkg::BWST_SIG_LO] != bwst_pkg::BWST_WDT_OFF_SIG);
   assign sel_eff = force_slow_r ? bwst_pkg::BWST_SEL_DIV4096
                                 : control_r[bwst_pkg::BWST_SEL_HI:bwst_pkg::BWST_SEL_LO];
   assign counting = (state_r != bwst_pkg::BWST_STOPPED);
   assign count_inc = {1'b0, count_r} + 9'h001;
   assign stab_carry = tick & (count_r[bwst_pkg::BWST_STAB_BIT:0] == '1);
   // Read selection; count is read-only, unmapped addresses read zero
   assign rdata_sel = (reg_addr == bwst_pkg::BWST_ADDR_CONTROL) ? control_r
                    : (reg_addr == bwst_pkg::BWST_ADDR_COUNT) ? count_r
                    : 8'h00;
   // interval ends on the carry out of bit 4
   assign stab_end = (state_r == bwst_pkg::BWST_STAB) & stab_carry;
   // carry out of bit 7; a clear in the same cycle wins
   assign wdt_fire = wdt_enabled & (state_r == bwst_pkg::BWST_RUN) & tick
                     & (count_r == '1) & ~clr_count;

   // prescaler with selection mux
   // Stopped state holds the divider clear, so stabilization starts
   // on a full prescaler period
   bwst_prescaler #(
      .DIV_WIDTH($clog2(bwst_pkg::BWST_DIV_MAX))
   ) u_prescaler (
      .clock(clock),
      .rst_n(rst_n),
      .clear(clr_div | ~counting),
      .select(sel_eff),
      .tick(tick)
   );

   // Counter next value: clear wins, else tick increments and wraps
   // The count is kept on wake, so the interval depends on its value
   // at stop; software clears it first to get a full interval
   always_comb begin
      count_nxt = count_r;
      if (clr_count) begin
         count_nxt = '0;
      end else if (tick & counting) begin
         count_nxt = count_inc[7:0];
      end
   end

   // State next value
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         bwst_pkg::BWST_RUN: begin
            // Stop is accepted only while running
            if (stop_request) begin
               state_nxt = bwst_pkg::BWST_STOPPED;
            end
         end
         bwst_pkg::BWST_STOPPED: begin
            // wake starts stabilization
            // A wake level must last at least one clock to be seen
            if (wake_rst | wake_int) begin
               state_nxt = bwst_pkg::BWST_STAB;
            end
         end
         bwst_pkg::BWST_STAB: begin
            if (stab_carry) begin
               state_nxt = bwst_pkg::BWST_RUN;
            end
         end
         default: state_nxt = bwst_pkg::BWST_RUN;
      endcase
   end

   // Input synchronisers: wake pins are asynchronous, and only the second
   // stage is read so a metastable first stage never reaches logic
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_int_sync_r <= 2'h0;
         wake_rst_sync_r <= 2'h0;
      end else begin
         wake_int_sync_r <= {wake_int_sync_r[0], wake_interrupt};
         wake_rst_sync_r <= {wake_rst_sync_r[0], wake_after_reset};
      end
   end

   // Control register; clear bits are strobes and do not stay set
   // Only the signature and selection fields are stored
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control_r <= bwst_pkg::BWST_CONTROL_RESET;
      end else if (wr_control) begin
         control_r <= {reg_wdata[bwst_pkg::BWST_SIG_HI:bwst_pkg::BWST_SEL_LO], 2'h0};
      end
   end

   // Counter and state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 8'h00;
         state_r <= bwst_pkg::BWST_RUN;
      end else begin
         count_r <= count_nxt;
         state_r <= state_nxt;
      end
   end

   // Stabilization rate: reset wake forces 4096, interrupt wake keeps selection
   // Cleared once back in run so the programmed selection applies again
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         force_slow_r <= 1'b0;
      end else if (state_r == bwst_pkg::BWST_STOPPED && (wake_rst | wake_int)) begin
         force_slow_r <= wake_rst;
      end else if (state_r == bwst_pkg::BWST_RUN) begin
         force_slow_r <= 1'b0;
      end
   end

   // Registered outputs; each top output leaves straight from a flop
   // so the chip reset request is free of glitches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         cpu_en_r <= 1'b1;
         done_r <= 1'b0;
         wdt_rst_r <= 1'b0;
      end else begin
         // Read data for the address presented this cycle
         rdata_r <= rdata_sel;
         cpu_en_r <= (state_nxt == bwst_pkg::BWST_RUN);
         done_r <= stab_end;
         wdt_rst_r <= wdt_fire;
      end
   end

   assign reg_rdata = rdata_r;
   assign cpu_clock_enable = cpu_en_r;
   assign stabilization_done = done_r;
   assign watchdog_reset = wdt_rst_r;
endmodule // bwst_timer
`default_nettype wire

// ---- sim/bwst_timer_checker.sv ----
// Port checker for the basic watchdog timer.
// Assumes it is bound to bwst_timer, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bwst_timer_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic stop_request,
   input wire logic wake_interrupt,
   input wire logic wake_after_reset,
   input wire logic cpu_clock_enable,
   input wire logic stabilization_done,
   input wire logic watchdog_reset
);
   logic [7:0] ctrl_r; // Last control write
   wire wr_ctl = reg_write && reg_addr == 8'hd3;
   wire sig_off = ctrl_r[7:4] == bwst_pkg::BWST_WDT_OFF_SIG;
   // Shadow of the control register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ctrl_r <= 8'h00;
      else if (wr_ctl) ctrl_r <= reg_wdata;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_ctl; wr_ctl ##1 (reg_addr == 8'hd3 && !reg_write); endsequence
   sequence s_clr; (wr_ctl && reg_wdata[1:0] == 2'b11) ##1 reg_addr == 8'hfd; endsequence
   sequence s_pulse; stabilization_done ##1 !stabilization_done; endsequence
   AST_CTRL_RDBK:
   assert property (s_ctl |=> reg_rdata == (ctrl_r & 8'hfc)) else $error("control readback");
   AST_CNT_CLR:
   assert property (s_clr |=> reg_rdata == 8'h00) else $error("count not cleared");
   AST_WD_ONE:
   assert property (watchdog_reset |=> !watchdog_reset) else $error("reset pulse long");
   AST_WD_OFF:
   assert property (watchdog_reset |-> !$past(sig_off)) else $error("reset while off");
   AST_WD_RUN:
   assert property (watchdog_reset |-> $past(cpu_clock_enable)) else $error("reset in stop");
   AST_STOP:
   assert property (stop_request && cpu_clock_enable |-> ##[1:2] !cpu_clock_enable)
      else $error("stop not taken");
   AST_DONE:
   assert property ($rose(stabilization_done) |-> cpu_clock_enable and s_pulse)
      else $error("done pulse wrong");
   AST_RESUME:
   assert property ($rose(cpu_clock_enable) |-> stabilization_done) else $error("early resume");
endmodule // bwst_timer_checker
bind bwst_timer bwst_timer_checker bwst_timer_checker_inst (.clock(clock), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .stop_request(stop_request), .wake_interrupt(wake_interrupt),
   .wake_after_reset(wake_after_reset), .cpu_clock_enable(cpu_clock_enable),
   .stabilization_done(stabilization_done), .watchdog_reset(watchdog_reset));
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the basic watchdog timer.
// Assumes bwst_timer on a 100 MHz clock with its checker bound.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_write = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic stop_request = 1'b0;
   logic wake_interrupt = 1'b0;
   logic wake_after_reset = 1'b0;
   logic rd_v = 1'b0; // Read result due
   wire [7:0] reg_rdata;
   wire cpu_clock_enable;
   wire stabilization_done;
   wire watchdog_reset;
   logic [7:0] exp_q[$]; // Expected reads
   int dv[4] = '{4096, 1024, 128, 16};
   int err_total = 0;
   int n_tests = 0;
   int seed = 32'h521b;
   int n;
   int k;
   bwst_timer bwst_timer_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .stop_request(stop_request), .wake_interrupt(wake_interrupt),
      .wake_after_reset(wake_after_reset), .cpu_clock_enable(cpu_clock_enable),
      .stabilization_done(stabilization_done), .watchdog_reset(watchdog_reset));
   // Clock
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic cmp(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      tick(1);
      reg_write = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      exp_q.push_back(e);
      tick(1);
      rd_v = 1'b1;
      tick(1);
      rd_v = 1'b0;
   endtask
   // Monitor: oldest expected read against the data
   always @(posedge clock) begin
      if (rd_v) cmp(reg_rdata === exp_q.pop_front(), "read value");
   end
   // Cycles until a pulse on watchdog (w) or stabilization end
   task automatic wait_p(input logic w, input int lim);
      n = 0;
      while (n < lim && (w ? watchdog_reset : stabilization_done) !== 1'b1) begin
         tick(1);
         n++;
      end
   endtask
   // Count to 30 at divide 16, then stop and wake
   task automatic stop_wake(input logic intr);
      wr(8'hd3, 8'haf);
      tick(484);
      stop_request = 1'b1;
      tick(1);
      stop_request = 1'b0;
      tick(2);
      cmp(cpu_clock_enable === 1'b0, "clock not gated");
      wake_interrupt = intr;
      wake_after_reset = !intr;
      tick(4);
      wake_interrupt = 1'b0;
      wake_after_reset = 1'b0;
   endtask
   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog on the run
   initial begin
      #600us;
      err_total++;
      complete_run();
   end
   initial begin
      tick(4);
      rst_n = 1'b1;
      tick(1);
      rd(8'hd3, 8'h00);
      rd(8'hfd, 8'h00);
      rd(8'h10, 8'h00);
      $display("reset test done");
      for (int s = 0; s < 4; s++) begin
         k = 1 + ($random(seed) & 1);
         wr(8'hd3, {4'ha, s[1:0], 2'b11});
         rd(8'hfd, 8'h00);
         wr(8'hfd, 8'($random(seed)));
         tick(k * dv[s] + dv[s] / 2);
         rd(8'hfd, k[7:0]);
         rd(8'hd3, {4'ha, s[1:0], 2'b00});
      end
      $display("divider test done");
      stop_wake(1'b1);
      wait_p(1'b0, 200);
      cmp(n > 20 && n < 60, "interrupt wake span");
      cmp(cpu_clock_enable === 1'b1, "clock not resumed");
      rd(8'hd3, 8'hac);
      stop_wake(1'b0);
      wait_p(1'b0, 9000);
      cmp(n > 7000 && n < 8400, "reset wake span");
      $display("stop test done");
      // Watchdog on at divide 16; software clears well before overflow
      wr(8'hd3, 8'h0f);
      repeat (3) begin
         wait_p(1'b1, 3000);
         cmp(n == 3000, "reset despite clears");
         wr(8'hd3, 8'h0e);
         rd(8'hfd, 8'h00);
      end
      $display("clear test done");
      wr(8'hd3, {1'b0, 3'($random(seed)), 4'hf});
      wait_p(1'b1, 5000);
      cmp(n > 4080 && n < 4110, "overflow reset span");
      wr(8'hd3, 8'haf);
      wait_p(1'b1, 4200);
      cmp(n == 4200, "reset while off");
      rd(8'hfd, 8'h06);
      $display("watchdog test done");
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
